// File: core/parallel_port_gpio_mux.sv
// Top: 16-pin parallel port with per-pin alternate functions
`timescale 1ns/100ps
`default_nettype none
module parallel_port_gpio_mux (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_reg_cs,
  input  wire logic        i_reg_we,
  input  wire logic [11:0] i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  output var  logic [15:0] o_reg_rdata,
  output var  logic        o_reg_ack,
  output var  logic        o_reg_hit,
  input  wire logic [15:0] i_port_pin,
  output var  logic [15:0] o_port_pin,
  output var  logic [15:0] o_port_pin_oe,
  input  wire logic [7:0]  i_addr_hi,
  input  wire logic        i_transfer_in_progress,
  input  wire logic [2:0]  i_transfer_modifier,
  input  wire logic [1:0]  i_transfer_type_out,
  input  wire logic        i_bus_master,
  output var  logic [1:0]  o_dma_request_in
);
  typedef struct packed {
    logic [15:0] rdata;
    logic        ack;
    logic        hit;
    logic [15:0] pin_out;
    logic [15:0] pin_oe;
    logic [1:0]  dma_request_in;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;
  logic [15:0] rdata_d;
  logic        hit_d;
  logic [15:0] pin_out_d;
  logic [15:0] pin_oe_d;
  logic [1:0]  dma_request_in_d;

  ppgpio_cfg_if cfg ();

  // One register port serves both the core and outside masters alike
  ppgpio_regs u_regs (
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (i_rst_n),
    .i_reg_cs   (i_reg_cs),
    .i_reg_we   (i_reg_we),
    .i_reg_addr (i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .o_rdata_d  (rdata_d),
    .o_hit      (hit_d),
    .cfg        (cfg.regs)
  );

  ppgpio_mux u_mux (
    .i_pin_in    (i_port_pin),
    .i_addr_hi   (i_addr_hi),
    .i_tip       (i_transfer_in_progress),
    .i_tm        (i_transfer_modifier),
    .i_tt        (i_transfer_type_out),
    .i_bus_master(i_bus_master),
    .o_pin_out_d (pin_out_d),
    .o_pin_oe_d  (pin_oe_d),
    .o_dma_request_in_d    (dma_request_in_d),
    .cfg         (cfg.mux)
  );

  // Next state: pin drive follows registers two cycles after a write
  always_comb begin
    s_d = s_q;
    s_d.ack     = i_reg_cs;
    s_d.hit     = i_reg_cs & hit_d;
    s_d.rdata   = (i_reg_cs && !i_reg_we) ? rdata_d : s_q.rdata;
    s_d.pin_out = pin_out_d;
    s_d.pin_oe  = pin_oe_d;
    s_d.dma_request_in    = dma_request_in_d;
  end

  // Registered outputs cost one cycle of latency but keep pins glitch free
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_reg_rdata   = s_q.rdata;
  assign o_reg_ack     = s_q.ack;
  assign o_reg_hit     = s_q.hit;
  assign o_port_pin    = s_q.pin_out;
  assign o_port_pin_oe = s_q.pin_oe;
  assign o_dma_request_in = s_q.dma_request_in;

  a_gpio_output_drive: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    ##1 (!cfg.func_sel[12] && cfg.direction[12]) |=> o_port_pin_oe[12]
    && o_port_pin[12] == $past(cfg.value[12]))
    else $error("port output pin does not follow value register");
  a_gpio_input_float: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (!cfg.func_sel[0] && !cfg.direction[0]) |=> !o_port_pin_oe[0])
    else $error("port input pin is driven");
  a_write_reaches_pin: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_reg_cs && i_reg_we && i_reg_addr == ppgpio_pkg::OFS_VALUE
     && cfg.direction[4] && !cfg.func_sel[4]
     && !(i_reg_addr == ppgpio_pkg::OFS_DIRECTION))
    |=> ##1 o_port_pin[4] == $past(i_reg_wdata[4], 2))
    else $error("value write did not reach output pin in two cycles");
  a_addr_alt_route: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cfg.func_sel[9] |=> o_port_pin[9] == $past(i_addr_hi[1]))
    else $error("address bit 25 not on pin 9");
  a_tip_route: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cfg.func_sel[7] |=> o_port_pin_oe[7] && o_port_pin[7] == $past(i_transfer_in_progress))
    else $error("transfer-in-progress not on pin 7");
  a_alt_ignores_value: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cfg.func_sel[2] |=> o_port_pin[2] == $past(i_transfer_modifier[0]))
    else $error("alternate pin follows value register");
  a_dma_request_in_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !cfg.func_sel[6] |=> !o_dma_request_in[0])
    else $error("dma request passed from a port pin");
  a_tt_master: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cfg.func_sel[0] |=> o_port_pin_oe[0] == $past(i_bus_master))
    else $error("transfer type drive not tied to bus mastership");
  a_read_input_pin: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_reg_cs && !i_reg_we && i_reg_addr == ppgpio_pkg::OFS_VALUE
     && !cfg.func_sel[3] && !cfg.direction[3])
    |=> o_reg_ack && o_reg_rdata[3] == $past(i_port_pin[3]))
    else $error("read of input pin wrong");

  // Per-pin checks of the port role. Every pin gets the same three checks, so a slip
  // in one lane of the generate loop in the mux cannot hide behind the
  // single-pin spot checks above.
  for (genvar p = 0; p < 16; p++) begin : g_port_chk
    // A port pin enables its driver exactly when its direction bit is set
    a_port_pin_oe: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      !cfg.func_sel[p]
      |=> o_port_pin_oe[p] == $past(cfg.direction[p]))
      else $error("port pin enable does not follow direction");

    // A driven port pin shows the stored value bit one cycle later
    a_port_pin_drive: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      !cfg.func_sel[p] && cfg.direction[p]
      |=> o_port_pin[p] == $past(cfg.value[p]))
      else $error("port output pin does not show stored bit");

    // A zero select bit always hands the pin back to the port
    a_port_pin_owner: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      !cfg.func_sel[p] && !cfg.direction[p]
      |=> !o_port_pin_oe[p])
      else $error("input port pin is driven by an alternate source");
  end

  // Upper address lanes: pin n carries address bit n+16 while mastering.
  // Drive is gated by mastership so that a second master on the bus is
  // never fought over the address lines.
  for (genvar p = 8; p < 16; p++) begin : g_addr_chk
    a_addr_pin_oe: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      cfg.func_sel[p]
      |=> o_port_pin_oe[p] == $past(i_bus_master))
      else $error("address pin drive not tied to bus mastership");

    a_addr_pin_drive: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      cfg.func_sel[p]
      |=> o_port_pin[p] == $past(i_addr_hi[p-8]))
      else $error("address bit not on its pin");
  end

  // Transfer modifier lanes: always driven once selected, whatever the
  // bus mastership, unlike the address and transfer type lanes.
  for (genvar p = 2; p < 5; p++) begin : g_tm_chk
    a_tm_pin_oe: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      cfg.func_sel[p]
      |=> o_port_pin_oe[p])
      else $error("transfer modifier pin not driven");

    a_tm_pin_drive: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      cfg.func_sel[p]
      |=> o_port_pin[p] == $past(i_transfer_modifier[p-2]))
      else $error("transfer modifier bit not on its pin");
  end

  // Transfer type lanes follow the type inputs while selected
  for (genvar p = 0; p < 2; p++) begin : g_tt_chk
    a_tt_pin_drive: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      cfg.func_sel[p]
      |=> o_port_pin[p] == $past(i_transfer_type_out[p]))
      else $error("transfer type bit not on its pin");
  end

  // DMA request lanes are inputs: never driven, and the level passes on
  a_dma_request_in_pin_float: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    cfg.func_sel[ppgpio_pkg::PIN_DREQ0] || cfg.func_sel[ppgpio_pkg::PIN_DREQ1]
    |=> !(o_port_pin_oe[6] && $past(cfg.func_sel[6]))
     && !(o_port_pin_oe[5] && $past(cfg.func_sel[5])))
    else $error("dma request pin is driven");

  a_dreq0_pass: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    cfg.func_sel[ppgpio_pkg::PIN_DREQ0]
    |=> o_dma_request_in[0] == $past(i_port_pin[6]))
    else $error("dma request 0 does not follow its pin");

  a_dreq1_pass: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    cfg.func_sel[ppgpio_pkg::PIN_DREQ1]
    |=> o_dma_request_in[1] == $past(i_port_pin[5]))
    else $error("dma request 1 does not follow its pin");

  a_dreq1_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !cfg.func_sel[ppgpio_pkg::PIN_DREQ1]
    |=> !o_dma_request_in[1])
    else $error("dma request 1 passed from a port pin");

  // Register bus answer: exactly one acknowledge per request cycle
  a_ack_follows_cs: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_reg_cs |=> o_reg_ack)
    else $error("register request not acknowledged");

  a_ack_no_spurious: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_reg_cs |=> !o_reg_ack && !o_reg_hit)
    else $error("acknowledge without a request");

  // Hit tells software whether the place it touched exists
  a_hit_mapped: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_reg_cs && (i_reg_addr == ppgpio_pkg::OFS_FUNC_SEL
              || i_reg_addr == ppgpio_pkg::OFS_DIRECTION
              || i_reg_addr == ppgpio_pkg::OFS_VALUE)
    |=> o_reg_hit)
    else $error("mapped register reported as missing");

  a_unmapped_read: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_reg_cs && !i_reg_we
    && i_reg_addr != ppgpio_pkg::OFS_FUNC_SEL
    && i_reg_addr != ppgpio_pkg::OFS_DIRECTION
    && i_reg_addr != ppgpio_pkg::OFS_VALUE
    |=> !o_reg_hit && o_reg_rdata == ppgpio_pkg::READ_UNMAPPED)
    else $error("unmapped read not refused");

  // Read data stands until the next read, so slow masters may pick it late
  a_rdata_hold: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !(i_reg_cs && !i_reg_we) |=> $stable(o_reg_rdata))
    else $error("read data changed without a read");

  a_func_readback: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_reg_cs && !i_reg_we && i_reg_addr == ppgpio_pkg::OFS_FUNC_SEL
    |=> o_reg_rdata == $past(cfg.func_sel))
    else $error("function select read back wrong");

  a_dir_readback: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_reg_cs && !i_reg_we && i_reg_addr == ppgpio_pkg::OFS_DIRECTION
    |=> o_reg_rdata == $past(cfg.direction))
    else $error("direction read back wrong");

  // Output pins read back the store, not the pad, so a shorted pin
  // does not corrupt read-modify-write sequences in software
  a_out_pin_read: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_reg_cs && !i_reg_we && i_reg_addr == ppgpio_pkg::OFS_VALUE
    && !cfg.func_sel[3] && cfg.direction[3]
    |=> o_reg_rdata[3] == $past(cfg.value[3]))
    else $error("read of output pin wrong");

  // Writing the value of an input pin must leave the pin undriven
  a_input_write_float: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_reg_cs && i_reg_we && i_reg_addr == ppgpio_pkg::OFS_VALUE
    && !cfg.func_sel[1] && !cfg.direction[1]
    ##1 !(i_reg_cs && i_reg_we)
    |=> !o_port_pin_oe[1])
    else $error("value write drove an input pin");

  // Upper port pins keep working while only two address lanes are selected
  a_mixed_port_pin: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    cfg.func_sel[9:8] == 2'h3 && !cfg.func_sel[10]
    |=> o_port_pin_oe[10] == $past(cfg.direction[10]))
    else $error("upper port pin lost while address lanes selected");

  // Selected alternate lanes never show the stored value of their bit
  a_alt_tip_value: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    cfg.func_sel[7] && cfg.value[7] != i_transfer_in_progress
    |=> o_port_pin[7] != $past(cfg.value[7]))
    else $error("alternate pin follows value register");

  c_value_write: cover property (@(posedge i_ref_clk)
    i_reg_cs && i_reg_we && i_reg_addr == ppgpio_pkg::OFS_VALUE);
  c_mixed_addr: cover property (@(posedge i_ref_clk)
    cfg.func_sel[9:8] == 2'h3 && cfg.func_sel[15:10] == 6'h00);
  c_input_read: cover property (@(posedge i_ref_clk)
    i_reg_cs && !i_reg_we && i_reg_addr == ppgpio_pkg::OFS_VALUE);
  c_unmapped: cover property (@(posedge i_ref_clk) i_reg_cs && !hit_d);
endmodule : parallel_port_gpio_mux
`default_nettype wire

// File: core/ppgpio_cfg_if.sv
// Interface: configuration and pin-sample carrier between register file and pin mux
`timescale 1ns/100ps
`default_nettype none
interface ppgpio_cfg_if;
  logic [15:0] func_sel;
  logic [15:0] direction;
  logic [15:0] value;
  logic [15:0] pin_level;
  modport regs (output func_sel, output direction, output value, input pin_level);
  modport mux  (input func_sel, input direction, input value, output pin_level);
endinterface : ppgpio_cfg_if
`default_nettype wire

// File: core/ppgpio_mux.sv
// Pin multiplexer: port I/O against alternate bus and DMA functions per pin
`timescale 1ns/100ps
`default_nettype none
module ppgpio_mux (
  input  wire logic [15:0] i_pin_in,
  input  wire logic [7:0]  i_addr_hi,
  input  wire logic        i_tip,
  input  wire logic [2:0]  i_tm,
  input  wire logic [1:0]  i_tt,
  input  wire logic        i_bus_master,
  output var  logic [15:0] o_pin_out_d,
  output var  logic [15:0] o_pin_oe_d,
  output var  logic [1:0]  o_dma_request_in_d,
  ppgpio_cfg_if.mux        cfg
);
  logic [15:0] alt_out;
  logic [15:0] alt_oe;

  // Alternate function per pin
  always_comb begin
    alt_out = '0;
    alt_oe  = '0;
    alt_out[15:ppgpio_pkg::PIN_A24] = i_addr_hi;
    alt_oe[15:ppgpio_pkg::PIN_A24]  = {8{i_bus_master}};
    alt_out[ppgpio_pkg::PIN_TIP]    = i_tip;
    alt_oe[ppgpio_pkg::PIN_TIP]     = 1'b1;
    alt_out[ppgpio_pkg::PIN_TM2]    = i_tm[2];
    alt_out[ppgpio_pkg::PIN_TM1]    = i_tm[1];
    alt_out[ppgpio_pkg::PIN_TM0]    = i_tm[0];
    alt_oe[ppgpio_pkg::PIN_TM2:ppgpio_pkg::PIN_TM0] = 3'h7;
    alt_out[ppgpio_pkg::PIN_TT1]    = i_tt[1];
    alt_out[ppgpio_pkg::PIN_TT0]    = i_tt[0];
    alt_oe[ppgpio_pkg::PIN_TT1:ppgpio_pkg::PIN_TT0] = {2{i_bus_master}};
  end

  // One selection per pin; each pin is independent of its neighbours
  for (genvar g = 0; g < 16; g++) begin : g_pin
    always_comb begin
      if (cfg.func_sel[g]) begin
        o_pin_out_d[g] = alt_out[g];
        o_pin_oe_d[g]  = alt_oe[g];
      end else begin
        o_pin_out_d[g] = cfg.value[g];
        o_pin_oe_d[g]  = cfg.direction[g];
      end
    end
  end

  // DMA requests only pass when the pin is in its alternate role
  assign o_dma_request_in_d[0] = cfg.func_sel[ppgpio_pkg::PIN_DREQ0] & i_pin_in[ppgpio_pkg::PIN_DREQ0];
  assign o_dma_request_in_d[1] = cfg.func_sel[ppgpio_pkg::PIN_DREQ1] & i_pin_in[ppgpio_pkg::PIN_DREQ1];
  assign cfg.pin_level = i_pin_in;
endmodule : ppgpio_mux
`default_nettype wire

// File: core/ppgpio_pkg.sv
// Package: register map, widths and reset values of the parallel port pin multiplexer
package ppgpio_pkg;
  localparam int unsigned PIN_COUNT = 16;
  localparam int unsigned ADDR_W    = 12;
  localparam logic [11:0] OFS_FUNC_SEL  = 12'h004;
  localparam logic [11:0] OFS_DIRECTION = 12'h244;
  localparam logic [11:0] OFS_VALUE     = 12'h248;
  localparam logic [15:0] RST_FUNC_SEL  = 16'h0000;
  localparam logic [15:0] RST_DIRECTION = 16'h0000;
  localparam logic [15:0] RST_VALUE     = 16'h0000;
  localparam logic [15:0] READ_UNMAPPED = 16'h0000;
  // Pin positions of the alternate functions
  localparam int unsigned PIN_TIP   = 7;
  localparam int unsigned PIN_DREQ0 = 6;
  localparam int unsigned PIN_DREQ1 = 5;
  localparam int unsigned PIN_TM2   = 4;
  localparam int unsigned PIN_TM1   = 3;
  localparam int unsigned PIN_TM0   = 2;
  localparam int unsigned PIN_TT1   = 1;
  localparam int unsigned PIN_TT0   = 0;
  localparam int unsigned PIN_A24   = 8;
  // Register select codes of the address decode in the register file
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_FUNC,
    SEL_DIR,
    SEL_VALUE
  } reg_sel_t;
endpackage : ppgpio_pkg

// File: core/ppgpio_regs.sv
// Register file: function select, direction and value registers with read mux
`timescale 1ns/100ps
`default_nettype none
module ppgpio_regs (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_reg_cs,
  input  wire logic              i_reg_we,
  input  wire logic [11:0]       i_reg_addr,
  input  wire logic [15:0]       i_reg_wdata,
  output var  logic [15:0]       o_rdata_d,
  output var  logic              o_hit,
  ppgpio_cfg_if.regs             cfg
);
  typedef struct packed {
    logic [15:0] func_sel;
    logic [15:0] direction;
    logic [15:0] value;
  } regs_state_t;

  regs_state_t s_q;
  regs_state_t s_d;
  ppgpio_pkg::reg_sel_t sel;
  logic [15:0] gpio_in;

  // Address decode
  always_comb begin
    case (i_reg_addr)
      ppgpio_pkg::OFS_FUNC_SEL:  sel = ppgpio_pkg::SEL_FUNC;
      ppgpio_pkg::OFS_DIRECTION: sel = ppgpio_pkg::SEL_DIR;
      ppgpio_pkg::OFS_VALUE:     sel = ppgpio_pkg::SEL_VALUE;
      default:                   sel = ppgpio_pkg::SEL_NONE;
    endcase
  end

  // Writes accepted at any time, from the core or an outside master
  always_comb begin
    s_d = s_q;
    if (i_reg_cs && i_reg_we) begin
      case (sel)
        ppgpio_pkg::SEL_FUNC:  s_d.func_sel  = i_reg_wdata;
        ppgpio_pkg::SEL_DIR:   s_d.direction = i_reg_wdata;
        ppgpio_pkg::SEL_VALUE: s_d.value     = i_reg_wdata;
        default:               s_d = s_q;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q.func_sel  <= ppgpio_pkg::RST_FUNC_SEL;
      s_q.direction <= ppgpio_pkg::RST_DIRECTION;
      s_q.value     <= ppgpio_pkg::RST_VALUE;
    end else begin
      s_q <= s_d;
    end
  end

  // Inputs that are port bits read the pin; everything else reads the store
  assign gpio_in = ~s_q.func_sel & ~s_q.direction;
  always_comb begin
    o_hit = (sel != ppgpio_pkg::SEL_NONE);
    case (sel)
      ppgpio_pkg::SEL_FUNC:  o_rdata_d = s_q.func_sel;
      ppgpio_pkg::SEL_DIR:   o_rdata_d = s_q.direction;
      ppgpio_pkg::SEL_VALUE: o_rdata_d = (gpio_in & cfg.pin_level)
                                       | (~gpio_in & s_q.value);
      default:               o_rdata_d = ppgpio_pkg::READ_UNMAPPED;
    endcase
  end

  assign cfg.func_sel  = s_q.func_sel;
  assign cfg.direction = s_q.direction;
  assign cfg.value     = s_q.value;

  a_write_value: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_reg_cs && i_reg_we && i_reg_addr == ppgpio_pkg::OFS_VALUE
    |=> s_q.value == $past(i_reg_wdata))
    else $error("value register did not take write");
  a_func_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_reg_cs && i_reg_we && i_reg_addr == ppgpio_pkg::OFS_FUNC_SEL
    |=> s_q.func_sel == $past(i_reg_wdata))
    else $error("function select did not take write");
  a_dir_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !(i_reg_cs && i_reg_we) |=> $stable(s_q))
    else $error("registers changed without a write");
endmodule : ppgpio_regs
`default_nettype wire

// File: verif/parallel_port_gpio_mux_bench.sv
// Bench: register and pin checks of the parallel port pin multiplexer
`timescale 1ns/100ps
`default_nettype none
module parallel_port_gpio_mux_bench;
  typedef struct {logic rd; logic [15:0] d; logic hit;} note_t;
  logic        clk, rst_n, cs, we, transfer_in_progress, bm, hit, ack;
  logic [11:0] addr;
  logic [15:0] wdata, rdata, pin_in, pin_out, pin_oe, ext, func, dir, val;
  logic [7:0]  ahi;
  logic [2:0]  tm;
  logic [1:0]  tt, dma_request_in;
  note_t       q[$];
  note_t       n;
  int          mismatches, n_tests;

  parallel_port_gpio_mux DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_reg_cs(cs),
    .i_reg_we(we), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_ack(ack), .o_reg_hit(hit), .i_port_pin(pin_in), .o_port_pin(pin_out),
    .o_port_pin_oe(pin_oe), .i_addr_hi(ahi), .i_transfer_in_progress(transfer_in_progress),
    .i_transfer_modifier(tm), .i_transfer_type_out(tt), .i_bus_master(bm),
    .o_dma_request_in(dma_request_in));
  ppgpio_board board (.i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_ext_level(ext),
    .o_pin_level(pin_in));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One register cycle; the expected answer is noted before the request goes out
  task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] d,
                     input logic [15:0] e, input logic h);
    @(posedge clk);
    #1;
    cs = 1'b1;
    we = w;
    addr = a;
    wdata = d;
    q.push_back('{~w, e, h});
    @(posedge clk);
    #1;
    cs = 1'b0;
  endtask

  // Read value: port inputs show the pin, everything else the stored bit
  function automatic logic [15:0] val_exp();
    return (val & (func | dir)) | (ext & ~func & ~dir);
  endfunction

  task automatic read_all();
    acc(1'b0, ppgpio_pkg::OFS_FUNC_SEL, 16'h0000, func, 1'b1);
    acc(1'b0, ppgpio_pkg::OFS_DIRECTION, 16'h0000, dir, 1'b1);
    acc(1'b0, ppgpio_pkg::OFS_VALUE, 16'h0000, val_exp(), 1'b1);
  endtask

  // Pins are compared only where driven, since undriven levels are left open
  task automatic check_pins();
    logic [15:0] alt_oe, alt_drv, oe_e;
    alt_oe = {{8{bm}}, 1'b1, 2'b00, 3'b111, {2{bm}}};
    alt_drv = {ahi, transfer_in_progress, 2'b00, tm, tt};
    oe_e = (func & alt_oe) | (~func & dir);
    check(pin_oe, oe_e);
    check(pin_out & oe_e, ((func & alt_drv) | (~func & val)) & oe_e);
    check({14'h0000, dma_request_in}, {14'h0000, func[5] & ext[5], func[6] & ext[6]});
  endtask

  // Results are taken off the queue as each acknowledge shows up
  always @(negedge clk) begin
    if (ack === 1'b1) begin
      if (q.size() == 0) begin
        check(rdata, 16'hffff);
      end else begin
        n = q.pop_front();
        check({15'h0000, hit}, {15'h0000, n.hit});
        if (n.rd) check(rdata, n.d);
      end
    end
  end

  initial begin
    #200000;
    mismatches++;
    conclude();
  end

  initial begin
    logic [15:0] fixed[4];
    fixed = '{16'h0000, 16'hffff, 16'h0300, 16'h00ff};
    {cs, we, transfer_in_progress, bm, addr, wdata, ahi, tm, tt} = '0;
    ext = 16'ha5c3;
    {func, dir, val} = '0;
    mismatches = 0;
    n_tests = 0;
    rst_n = 1'b0;
    void'($urandom(83));
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    // Everything starts as port inputs
    check_pins();
    read_all();
    // Unmapped place: write dropped, read gives zero without a hit
    acc(1'b1, 12'h100, 16'hffff, 16'h0000, 1'b0);
    acc(1'b0, 12'h100, 16'h0000, ppgpio_pkg::READ_UNMAPPED, 1'b0);
    read_all();
    // Fixed corner maps first, including upper port pins beside two address pins
    for (int i = 0; i < 48; i++) begin
      func = (i < 4) ? fixed[i] : 16'($urandom);
      dir = 16'($urandom);
      val = 16'($urandom);
      ext = 16'($urandom);
      {ahi, transfer_in_progress, tm, tt, bm} = 15'($urandom);
      acc(1'b1, ppgpio_pkg::OFS_FUNC_SEL, func, 16'h0000, 1'b1);
      acc(1'b1, ppgpio_pkg::OFS_DIRECTION, dir, 16'h0000, 1'b1);
      acc(1'b1, ppgpio_pkg::OFS_VALUE, val, 16'h0000, 1'b1);
      @(posedge clk);
      #1;
      check_pins();
      read_all();
      // A second value write lands at once on output pins only
      val = ~val;
      acc(1'b1, ppgpio_pkg::OFS_VALUE, val, 16'h0000, 1'b1);
      @(posedge clk);
      #1;
      check_pins();
    end
    repeat (4) @(posedge clk);
    check({16'(q.size())}, 16'h0000);
    conclude();
  end
endmodule // parallel_port_gpio_mux_bench
`default_nettype wire

// File: verif/ppgpio_board.sv
// Board model: external logic seen by the sixteen port pins
`timescale 1ns/100ps
`default_nettype none
module ppgpio_board (
  input  wire logic [15:0] i_pin_out,
  input  wire logic [15:0] i_pin_oe,
  input  wire logic [15:0] i_ext_level,
  output var  logic [15:0] o_pin_level
);
  // Driven pins read back their own drive; the rest follow the board pattern
  always_comb begin
    o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_level);
  end
endmodule // ppgpio_board
`default_nettype wire
